// ==== core/pmx_code_decode.sv ====
// pin function select: 4-bit select code to one-hot function slot
// assumes codes outside 0/1h/2h/4h/8h are reserved
`timescale 1ns/1ns
`default_nettype none

module pmx_code_decode (
  // select code
  input  wire logic [3:0] code_in,
  // one-hot slot, all zero for reserved codes
  output logic [4:0]      slot_sel_out
);

  always_comb
  begin
    slot_sel_out = 5'h00;
    case (code_in)
      pmx_pkg::CODE_0:  slot_sel_out[pmx_pkg::SLOT_C0] = 1'b1;
      pmx_pkg::CODE_1H: slot_sel_out[pmx_pkg::SLOT_C1] = 1'b1;
      pmx_pkg::CODE_2H: slot_sel_out[pmx_pkg::SLOT_C2] = 1'b1;
      pmx_pkg::CODE_4H: slot_sel_out[pmx_pkg::SLOT_C4] = 1'b1;
      pmx_pkg::CODE_8H: slot_sel_out[pmx_pkg::SLOT_C8] = 1'b1;
      default:          slot_sel_out = 5'h00;
    endcase
  end

endmodule : pmx_code_decode

`default_nettype wire

// ==== core/pmx_pad_cell.sv ====
// pin function select: one pad, five function slots
// assumes an unused slot is fed pmx_pkg::FN_OFF
`timescale 1ns/1ns
`default_nettype none

module pmx_pad_cell (
  // slot choice and sources
  input  wire logic [4:0]              slot_sel_in,
  input  wire pmx_pkg::pmx_fn_s [4:0]  slot_src_in,
  // pad side
  input  wire logic                    pad_level_in,
  output var  pmx_pkg::pmx_pad_s       pad_drive_out,
  // pad level back to the chosen slot only
  output logic [4:0]                   slot_level_out
);

  always_comb
  begin
    pad_drive_out = pmx_pkg::PAD_HIZ;
    for (int k = 0; k < 5; k++)
    begin
      if (slot_sel_in[k])
      begin
        pad_drive_out.dout = slot_src_in[k].dout;
        pad_drive_out.oe_n = ~slot_src_in[k].drive;
      end
    end
  end

  assign slot_level_out = slot_sel_in & {5{pad_level_in}};

endmodule : pmx_pad_cell

`default_nettype wire

// ==== core/pmx_pin_function_select.sv ====
// pin function select for ten pads behind two 32-bit select words
// assumes an avalon-mm master on clock_in and pads resolved outside
`timescale 1ns/1ns
`default_nettype none

module pmx_pin_function_select (
  // clock and reset
  input  wire logic                 clock_in,
  input  wire logic                 reset_n_in,
  // avalon-mm slave
  input  wire logic [3:0]           address_in,
  input  wire logic                 read_in,
  input  wire logic                 write_in,
  input  wire logic [3:0]           byteenable_in,
  input  wire logic [31:0]          writedata_in,
  output logic [31:0]               readdata_out,
  output logic [1:0]                response_out,
  output logic                      waitrequest_out,
  // pads
  input  wire logic [9:0]           pad_level_in,
  output var  pmx_pkg::pmx_pad_s [9:0] pad_drive_out,
  // external memory address bits 6 and 7
  input  wire logic [1:0]           ext_mem_addr_in,
  // gpio bank 5 bits 6 and 7
  input  wire logic [1:0]           gpio_bank5_dout_in,
  input  wire logic [1:0]           gpio_bank5_drive_in,
  output logic [1:0]                gpio_bank5_level_out,
  // gpio bank 6 bits 8 to 15
  input  wire logic [7:0]           gpio_bank6_dout_in,
  input  wire logic [7:0]           gpio_bank6_drive_in,
  output logic [7:0]                gpio_bank6_level_out,
  // real-time units
  input  wire logic [5:0]           rt_unit0_out_in,
  input  wire logic [4:0]           rt_unit1_out_in,
  output logic                      rt_unit1_in_out,
  // host port
  input  wire logic                 host_port_irq_in,
  input  wire logic                 host_port_rdy_in,
  output logic                      host_port_rw_strobe_out,
  output logic                      host_port_halfword_sel_out,
  output logic                      host_port_ctl1_out,
  output logic                      host_port_ctl0_out,
  output logic                      host_port_data_strobe2_out,
  output logic                      host_port_addr_strobe_out,
  // parallel port channel 1: wait, enable, begin, clock
  input  wire logic [3:0]           par_ch1_dout_in,
  input  wire logic [3:0]           par_ch1_drive_in,
  output logic [3:0]                par_ch1_level_out,
  // observation clock and reset output
  input  wire logic                 observe_clock0_in,
  input  wire logic                 reset_output_pin_in
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  localparam int PAD_NUM  = pmx_pkg::PAD_NUM;
  localparam int SLOT_NUM = pmx_pkg::SLOT_NUM;
  localparam int FW       = pmx_pkg::FIELD_W;

  logic [31:0]            word12_ff;
  logic [31:0]            word13_ff;
  logic                   ack_ff;
  logic [31:0]            readdata_ff;
  logic [1:0]             response_ff;
  logic [31:0]            nxt_readdata;
  logic [1:0]             nxt_response;
  logic                   req;
  logic                   commit_wr;
  logic [31:0]            be_mask;
  logic [3:0]             pad_code [PAD_NUM];
  logic [SLOT_NUM-1:0]    slot_sel [PAD_NUM];
  logic [SLOT_NUM-1:0]    slot_lvl [PAD_NUM];
  pmx_pkg::pmx_fn_s [SLOT_NUM-1:0] slot_src [PAD_NUM];

  // ---------------------------------------------------------------
  // bus handshake: one wait cycle, then done
  // ---------------------------------------------------------------
  assign req             = read_in | write_in;
  assign waitrequest_out = req & ~ack_ff;
  assign commit_wr       = write_in & ack_ff;
  assign readdata_out    = readdata_ff;
  assign response_out    = response_ff;

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // ---------------------------------------------------------------
  // read path and decode answer
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_readdata = pmx_pkg::READ_ZERO;
    nxt_response = pmx_pkg::RESP_OKAY;
    case (address_in)
      pmx_pkg::OFS_WORD12: nxt_readdata = word12_ff;
      pmx_pkg::OFS_WORD13: nxt_readdata = word13_ff;
      default:             nxt_response = pmx_pkg::RESP_DECERR;
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      readdata_ff <= pmx_pkg::READ_ZERO;
      response_ff <= pmx_pkg::RESP_OKAY;
    end
    else if (req && !ack_ff)
    begin
      readdata_ff <= read_in ? nxt_readdata : pmx_pkg::READ_ZERO;
      response_ff <= nxt_response;
    end
  end

  // ---------------------------------------------------------------
  // select words with byte enables
  // ---------------------------------------------------------------
  always_comb
  begin
    be_mask = 32'h0000_0000;
    for (int b = 0; b < 4; b++)
    begin
      be_mask[b*8 +: 8] = {8{byteenable_in[b]}};
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      word12_ff <= pmx_pkg::WORD12_RST;
    end
    else if (commit_wr && address_in == pmx_pkg::OFS_WORD12)
    begin
      word12_ff <= (word12_ff & ~be_mask) | (writedata_in & be_mask);
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      word13_ff <= pmx_pkg::WORD13_RST;
    end
    else if (commit_wr && address_in == pmx_pkg::OFS_WORD13)
    begin
      word13_ff <= (word13_ff & ~be_mask) | (writedata_in & be_mask);
    end
  end

  // ---------------------------------------------------------------
  // field to pad codes
  // ---------------------------------------------------------------
  assign pad_code[0] = word12_ff[pmx_pkg::W12_LSB_7_4   +: FW];
  assign pad_code[1] = word12_ff[pmx_pkg::W12_LSB_3_0   +: FW];
  assign pad_code[2] = word13_ff[pmx_pkg::W13_LSB_31_28 +: FW];
  assign pad_code[3] = word13_ff[pmx_pkg::W13_LSB_27_24 +: FW];
  assign pad_code[4] = word13_ff[pmx_pkg::W13_LSB_23_20 +: FW];
  assign pad_code[5] = word13_ff[pmx_pkg::W13_LSB_19_16 +: FW];
  assign pad_code[6] = word13_ff[pmx_pkg::W13_LSB_15_12 +: FW];
  assign pad_code[7] = word13_ff[pmx_pkg::W13_LSB_11_8  +: FW];
  assign pad_code[8] = word13_ff[pmx_pkg::W13_LSB_7_4   +: FW];
  assign pad_code[9] = word13_ff[pmx_pkg::W13_LSB_3_0   +: FW];

  // ---------------------------------------------------------------
  // function sources per pad slot
  // ---------------------------------------------------------------
  always_comb
  begin
    for (int p = 0; p < PAD_NUM; p++)
    begin
      slot_src[p] = {SLOT_NUM{pmx_pkg::FN_OFF}};
    end
    // pad 0
    slot_src[0][pmx_pkg::SLOT_C1] =
      pmx_pkg::fn_drv(ext_mem_addr_in[0]);
    slot_src[0][pmx_pkg::SLOT_C8] =
      pmx_pkg::fn_bidir(gpio_bank5_drive_in[0],
                        gpio_bank5_dout_in[0]);
    // pad 1
    slot_src[1][pmx_pkg::SLOT_C1] =
      pmx_pkg::fn_drv(ext_mem_addr_in[1]);
    slot_src[1][pmx_pkg::SLOT_C4] =
      pmx_pkg::fn_drv(rt_unit1_out_in[4]);
    slot_src[1][pmx_pkg::SLOT_C8] =
      pmx_pkg::fn_bidir(gpio_bank5_drive_in[1],
                        gpio_bank5_dout_in[1]);
    // pads 2 to 7: rt unit 0 outputs 26..31 on code 1h
    for (int p = 2; p < 8; p++)
    begin
      slot_src[p][pmx_pkg::SLOT_C1] =
        pmx_pkg::fn_drv(rt_unit0_out_in[p-2]);
    end
    // pads 2 to 5: parallel channel 1 on code 4h
    for (int p = 2; p < 6; p++)
    begin
      slot_src[p][pmx_pkg::SLOT_C4] =
        pmx_pkg::fn_bidir(par_ch1_drive_in[p-2],
                          par_ch1_dout_in[p-2]);
    end
    // pads 6 to 9: rt unit 1 outputs 11..14 on code 4h
    for (int p = 6; p < 10; p++)
    begin
      slot_src[p][pmx_pkg::SLOT_C4] =
        pmx_pkg::fn_drv(rt_unit1_out_in[p-6]);
    end
    // pads 2 to 9: gpio bank 6 bits 8..15 on code 8h
    for (int p = 2; p < 10; p++)
    begin
      slot_src[p][pmx_pkg::SLOT_C8] =
        pmx_pkg::fn_bidir(gpio_bank6_drive_in[p-2],
                          gpio_bank6_dout_in[p-2]);
    end
    // host port outputs
    slot_src[6][pmx_pkg::SLOT_C2] =
      pmx_pkg::fn_drv(host_port_irq_in);
    slot_src[7][pmx_pkg::SLOT_C2] =
      pmx_pkg::fn_drv(host_port_rdy_in);
    // observation clock
    slot_src[8][pmx_pkg::SLOT_C1] =
      pmx_pkg::fn_drv(observe_clock0_in);
    // reset output on both code 0 and code 1h
    slot_src[9][pmx_pkg::SLOT_C0] =
      pmx_pkg::fn_drv(reset_output_pin_in);
    slot_src[9][pmx_pkg::SLOT_C1] =
      pmx_pkg::fn_drv(reset_output_pin_in);
  end

  // ---------------------------------------------------------------
  // per-pad decode and routing
  // ---------------------------------------------------------------
  for (genvar g = 0; g < PAD_NUM; g++)
  begin : g_pad
    pmx_code_decode u_dec (
      .code_in      (pad_code[g]),
      .slot_sel_out (slot_sel[g])
    );

    pmx_pad_cell u_cell (
      .slot_sel_in    (slot_sel[g]),
      .slot_src_in    (slot_src[g]),
      .pad_level_in   (pad_level_in[g]),
      .pad_drive_out  (pad_drive_out[g]),
      .slot_level_out (slot_lvl[g])
    );
  end

  // ---------------------------------------------------------------
  // pad levels back to peripherals
  // ---------------------------------------------------------------
  assign gpio_bank5_level_out[0] =
    slot_lvl[0][pmx_pkg::SLOT_C8];
  assign gpio_bank5_level_out[1] =
    slot_lvl[1][pmx_pkg::SLOT_C8];

  for (genvar g = 0; g < 8; g++)
  begin : g_gp6
    assign gpio_bank6_level_out[g] =
      slot_lvl[g+2][pmx_pkg::SLOT_C8];
  end

  for (genvar g = 0; g < 4; g++)
  begin : g_par
    assign par_ch1_level_out[g] =
      slot_lvl[g+2][pmx_pkg::SLOT_C4];
  end

  assign rt_unit1_in_out =
    slot_lvl[2][pmx_pkg::SLOT_C0];
  assign host_port_rw_strobe_out =
    slot_lvl[2][pmx_pkg::SLOT_C2];
  assign host_port_halfword_sel_out =
    slot_lvl[3][pmx_pkg::SLOT_C2];
  assign host_port_ctl1_out =
    slot_lvl[4][pmx_pkg::SLOT_C2];
  assign host_port_ctl0_out =
    slot_lvl[5][pmx_pkg::SLOT_C2];
  assign host_port_data_strobe2_out =
    slot_lvl[8][pmx_pkg::SLOT_C2];
  assign host_port_addr_strobe_out =
    slot_lvl[9][pmx_pkg::SLOT_C2];

endmodule : pmx_pin_function_select

`default_nettype wire

// ==== core/pmx_pkg.sv ====
// pin function select: constants, field map and carrier types
// assumes a 50 MHz configuration clock and a 32-bit avalon-mm slave port
package pmx_pkg;

  // ---------------------------------------------------------------
  // bus and register map
  // ---------------------------------------------------------------
  localparam int          DATA_W     = 32;
  localparam int          ADDR_W     = 4;
  localparam int          BE_W       = DATA_W / 8;
  localparam logic [3:0]  OFS_WORD12 = 4'h0;
  localparam logic [3:0]  OFS_WORD13 = 4'h4;
  localparam logic [31:0] WORD12_RST = 32'h0000_0000;
  localparam logic [31:0] WORD13_RST = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO  = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  // ---------------------------------------------------------------
  // field positions (lsb of each 4-bit select field)
  // ---------------------------------------------------------------
  localparam int FIELD_W       = 4;
  localparam int W12_LSB_7_4   = 4;
  localparam int W12_LSB_3_0   = 0;
  localparam int W13_LSB_31_28 = 28;
  localparam int W13_LSB_27_24 = 24;
  localparam int W13_LSB_23_20 = 20;
  localparam int W13_LSB_19_16 = 16;
  localparam int W13_LSB_15_12 = 12;
  localparam int W13_LSB_11_8  = 8;
  localparam int W13_LSB_7_4   = 4;
  localparam int W13_LSB_3_0   = 0;

  // ---------------------------------------------------------------
  // pads and function slots
  // ---------------------------------------------------------------
  localparam int PAD_NUM  = 10;
  localparam int SLOT_NUM = 5;
  localparam int SLOT_C0  = 0;
  localparam int SLOT_C1  = 1;
  localparam int SLOT_C2  = 2;
  localparam int SLOT_C4  = 3;
  localparam int SLOT_C8  = 4;
  localparam logic [3:0] CODE_0  = 4'h0;
  localparam logic [3:0] CODE_1H = 4'h1;
  localparam logic [3:0] CODE_2H = 4'h2;
  localparam logic [3:0] CODE_4H = 4'h4;
  localparam logic [3:0] CODE_8H = 4'h8;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic drive;
    logic dout;
  } pmx_fn_s;

  typedef struct packed {
    logic dout;
    logic oe_n;
  } pmx_pad_s;

  localparam pmx_fn_s  FN_OFF   = 2'h0;
  localparam pmx_pad_s PAD_HIZ  = 2'h1;

  // output-only function: always drives when chosen
  function automatic pmx_fn_s fn_drv(input logic d);
    fn_drv = '{drive: 1'b1, dout: d};
  endfunction : fn_drv

  // two-way function: peripheral decides when it drives
  function automatic pmx_fn_s fn_bidir(input logic en, input logic d);
    fn_bidir = '{drive: en, dout: d};
  endfunction : fn_bidir

endpackage : pmx_pkg

// ==== sim/pmx_pad_world.sv ====
// pad world: external parties on the ten pads
// assumes the block's pad drive struct and one clock
`timescale 1ns/1ns
`default_nettype none

module pmx_pad_world (
  // clock
  input  wire logic                    clock_in,
  // block side and external drivers
  input  wire pmx_pkg::pmx_pad_s [9:0] pad_drive_in,
  input  wire logic [9:0]              ext_en_in,
  input  wire logic [9:0]              ext_val_in,
  // resolved pad level
  output logic [9:0]                   pad_level_out
);
  // ----
  // floating pads wander; outsiders back off while the block drives
  // ----
  logic [9:0] wander_ff = 10'h155;
  always @(posedge clock_in)
    wander_ff <= ~wander_ff;
  always_comb
    for (int p = 0; p < 10; p++)
      pad_level_out[p] = !pad_drive_in[p].oe_n ? pad_drive_in[p].dout :
                         ext_en_in[p] ? ext_val_in[p] : wander_ff[p];
endmodule : pmx_pad_world
`default_nettype wire

// ==== sim/pmx_pin_function_select_asserts.sv ====
// checker for the pin function select block: bus timing and pad routing
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ns
`default_nettype none

module pmx_checker (
  // clock, reset, register bus
  input wire logic                    clock_in,
  input wire logic                    reset_n_in,
  input wire logic [3:0]              address_in,
  input wire logic                    read_in,
  input wire logic                    write_in,
  input wire logic [3:0]              byteenable_in,
  input wire logic [31:0]             writedata_in,
  input wire logic [31:0]             readdata_out,
  input wire logic [1:0]              response_out,
  input wire logic                    waitrequest_out,
  // pads and sources
  input wire logic [9:0]              pad_level_in,
  input wire pmx_pkg::pmx_pad_s [9:0] pad_drive_out,
  input wire logic [4:0]              rt_unit1_out_in,
  input wire logic                    rt_unit1_in_out,
  input wire logic                    host_port_irq_in,
  input wire logic                    reset_output_pin_in
);
  // ----
  // shadows of both words from completed writes
  // ----
  logic [31:0] sh12_ff, sh13_ff, wm;
  assign wm = {{8{byteenable_in[3]}}, {8{byteenable_in[2]}},
               {8{byteenable_in[1]}}, {8{byteenable_in[0]}}};
  always_ff @(posedge clock_in)
    if (!reset_n_in)
    begin
      sh12_ff <= '0;
      sh13_ff <= '0;
    end
    else if (write_in && !waitrequest_out)
    begin
      if (address_in == 4'h0) sh12_ff <= sh12_ff & ~wm | writedata_in & wm;
      if (address_in == 4'h4) sh13_ff <= sh13_ff & ~wm | writedata_in & wm;
    end
  // ----
  // properties
  // ----
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_stall;
    (read_in || write_in) && waitrequest_out;
  endsequence
  sequence s_done;
    (read_in || write_in) && !waitrequest_out;
  endsequence
  a_one_wait: assert property (s_stall |=> s_done)
    else $error("transfer not done after one wait cycle");
  a_read_data: assert property (read_in && !waitrequest_out &&
    address_in inside {4'h0, 4'h4} |->
    readdata_out == (address_in[2] ? sh13_ff : sh12_ff))
    else $error("read data differs from last write");
  a_read_resp: assert property (read_in && !waitrequest_out |->
    response_out == (address_in inside {4'h0, 4'h4} ? 2'h0 : 2'h3))
    else $error("wrong read response");
  a_reset_state: assert property ($rose(reset_n_in) |->
    readdata_out == 32'h0 && pad_drive_out[0] == pmx_pkg::PAD_HIZ &&
    !pad_drive_out[9].oe_n)
    else $error("pads or read data not in reset state");
  a_pad1_rt1: assert property (sh12_ff[3:0] == 4'h4 |->
    pad_drive_out[1] == {rt_unit1_out_in[4], 1'b0})
    else $error("pad 1 not driven by rt unit 1 bit 15");
  a_rt1_input: assert property (sh13_ff[31:28] == 4'h0 |->
    rt_unit1_in_out == pad_level_in[2] && pad_drive_out[2].oe_n)
    else $error("pad 2 level not routed to rt unit 1");
  a_irq_route: assert property (sh13_ff[15:12] == 4'h2 |->
    pad_drive_out[6] == {host_port_irq_in, 1'b0})
    else $error("pad 6 not driven by host irq");
  a_pad9_reset: assert property (sh13_ff[3:1] == 3'h0 |->
    pad_drive_out[9] == {reset_output_pin_in, 1'b0})
    else $error("pad 9 not driven by reset output");
  a_reserved_hiz: assert property (
    !(sh13_ff[31:28] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8}) |->
    pad_drive_out[2] == pmx_pkg::PAD_HIZ && !rt_unit1_in_out)
    else $error("reserved code does not float pad 2");
endmodule : pmx_checker

bind pmx_pin_function_select pmx_checker i_chk (.*);
`default_nettype wire

// ==== sim/pmx_pin_function_select_tb_top.sv ====
// self-checking bench for the pin function select block
// assumes the pad world model and the bound checker
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin bad_count++; \
  $display("Error %s expected %h seen %h", n, e, a); end end

module pmx_pin_function_select_tb_top;
  logic clock_in = 0, reset_n_in = 0, read_in = 0, write_in = 0, wq;
  logic [3:0] address_in = '0, byteenable_in = '0, pd = '0, pe = '0;
  logic [31:0] writedata_in = '0, w12 = '0, w13 = '0, rd, rdata;
  logic [1:0] rs, resp, ema = '0, g5d = '0, g5e = '0;
  logic [7:0] g6d = '0, g6e = '0;
  logic [5:0] rt0 = '0;
  logic [4:0] rt1 = '0;
  logic [9:0] ext_en = '0, ext_val = '0;
  logic irq = 0, rdy = 0, obs = 0, rso = 0;
  wire [1:0] g5l;
  wire [7:0] g6l;
  wire [5:0] hp;
  wire [3:0] pl;
  wire [9:0] lvl;
  wire rt1i;
  pmx_pkg::pmx_pad_s [9:0] pdrv;
  int bad_count = 0, checked = 0;
  integer seed = 32'hAD07359C;

  pmx_pin_function_select i_dut (.clock_in(clock_in),
    .reset_n_in(reset_n_in), .address_in(address_in), .read_in(read_in),
    .write_in(write_in), .byteenable_in(byteenable_in),
    .writedata_in(writedata_in), .readdata_out(rdata), .response_out(resp),
    .waitrequest_out(wq), .pad_level_in(lvl), .pad_drive_out(pdrv),
    .ext_mem_addr_in(ema), .gpio_bank5_dout_in(g5d),
    .gpio_bank5_drive_in(g5e), .gpio_bank5_level_out(g5l),
    .gpio_bank6_dout_in(g6d), .gpio_bank6_drive_in(g6e),
    .gpio_bank6_level_out(g6l), .rt_unit0_out_in(rt0),
    .rt_unit1_out_in(rt1), .rt_unit1_in_out(rt1i), .host_port_irq_in(irq),
    .host_port_rdy_in(rdy), .host_port_rw_strobe_out(hp[5]),
    .host_port_halfword_sel_out(hp[4]), .host_port_ctl1_out(hp[3]),
    .host_port_ctl0_out(hp[2]), .host_port_data_strobe2_out(hp[1]),
    .host_port_addr_strobe_out(hp[0]), .par_ch1_dout_in(pd),
    .par_ch1_drive_in(pe), .par_ch1_level_out(pl),
    .observe_clock0_in(obs), .reset_output_pin_in(rso));
  pmx_pad_world i_pads (.clock_in(clock_in), .pad_drive_in(pdrv),
    .ext_en_in(ext_en), .ext_val_in(ext_val), .pad_level_out(lvl));

  initial
  begin
    forever #10 clock_in = ~clock_in;
  end

  // ----
  // expected routing
  // ----
  function automatic logic [3:0] code(input int p);
    return p < 2 ? w12[7 - 4 * p -: 4] : w13[39 - 4 * p -: 4];
  endfunction : code

  function automatic logic hit(input int p, input logic [3:0] c);
    return lvl[p] && code(p) == c;
  endfunction : hit

  function automatic pmx_pkg::pmx_pad_s exp_pad(input int p);
    logic [4:0] dr, dv;
    logic [3:0] c;
    int s;
    c = code(p);
    dr = '0;
    dv = '0;
    s = c == 0 ? 0 : c == 1 ? 1 : c == 2 ? 2 : c == 4 ? 3 : c == 8 ? 4 : 5;
    dr[1] = 1'b1;
    if (p < 2) {dv[1], dr[4], dv[4]} = {ema[p], g5e[p], g5d[p]};
    else {dv[1], dr[4], dv[4]} = {p < 8 ? rt0[p - 2] : p == 8 ? obs : rso,
                                   g6e[p - 2], g6d[p - 2]};
    if (p == 1) {dr[3], dv[3]} = {1'b1, rt1[4]};
    if (p > 1 && p < 6) {dr[3], dv[3]} = {pe[p - 2], pd[p - 2]};
    if (p > 5) {dr[3], dv[3]} = {1'b1, rt1[p - 6]};
    if (p == 6 || p == 7) {dr[2], dv[2]} = {1'b1, p == 6 ? irq : rdy};
    if (p == 9) {dr[0], dv[0]} = {1'b1, rso};
    if (p < 2 && s == 2 || p == 0 && s == 3) s = 5;
    return s < 5 ? {dv[s], ~dr[s]} : pmx_pkg::PAD_HIZ;
  endfunction : exp_pad

  task automatic check_all();
    logic [20:0] e;
    e = '0;
    for (int p = 0; p < 10; p++)
    begin
      if (p < 2) `CHK("pad_drive", exp_pad(p), pdrv[p])
      else `CHK("pad_drive", exp_pad(p), pdrv[p])
      e[p < 2 ? 19 + p : 9 + p] = hit(p, 4'h8);
      if (p > 1 && p < 6) e[5 + p] = hit(p, 4'h4);
    end
    e[6:0] = {hit(2, 4'h0), hit(2, 4'h2), hit(3, 4'h2), hit(4, 4'h2),
              hit(5, 4'h2), hit(8, 4'h2), hit(9, 4'h2)};
    `CHK("levels", e, {g5l, g6l, pl, rt1i, hp})
  endtask : check_all

  // ----
  // stimulus and bus tasks
  // ----
  task automatic stir();
    logic [63:0] r;
    r = {$random(seed), $random(seed)};
    @(posedge clock_in);
    {ema, g5d, g5e, g6d, g6e, rt0, rt1, irq, rdy, pd, pe, obs} <= r[43:0];
    rso <= r[44];
    {ext_en, ext_val} <= r[63:44];
    @(negedge clock_in);
    check_all();
  endtask : stir

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge clock_in);
    {address_in, writedata_in, byteenable_in} <= {a, d, be};
    {write_in, read_in} <= {w, !w};
    for (n = 0; n < 20; n++)
    begin
      @(posedge clock_in);
      if (wq === 1'b0) break;
    end
    if (n == 20) bad_count++;
    if (n == 20) final_report();
    {rd, rs} = {rdata, resp};
    {write_in, read_in} <= 2'h0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    bus(1'b1, a, d, be);
    if (a == 4'h0) w12 = w12 & ~m | d & m;
    if (a == 4'h4) w13 = w13 & ~m | d & m;
    @(negedge clock_in);
    check_all();
  endtask : wr

  task automatic rdc(input logic [3:0] a);
    bus(1'b0, a, $random(seed), 4'hF);
    `CHK("readdata", a[3] ? 32'h0 : a[2] ? w13 : w12, rd)
    `CHK("response", a[3] ? 2'h3 : 2'h0, rs)
  endtask : rdc

  task automatic final_report();
    if (bad_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  initial
  begin
    static logic [3:0] cl [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8,
                                  4'h9, 4'hF};
    logic [31:0] d;
    logic [3:0] a;
    repeat (20) @(posedge clock_in);
    reset_n_in <= 1'b1;
    @(negedge clock_in);
    check_all();
    for (int k = 0; k < 16; k += 4) rdc(4'(k));
    foreach (cl[i])
    begin
      wr(4'h0, {24'h5A5A5A, cl[i], cl[i]}, 4'hF);
      wr(4'h4, {8{cl[i]}}, 4'hF);
      repeat (4) stir();
    end
    repeat (80)
    begin
      for (int k = 0; k < 8; k++) d[4 * k +: 4] = cl[$random(seed) & 7];
      a = 4'($random(seed)) & 4'hC;
      wr(a, d, 4'($random(seed)));
      rdc(a);
      stir();
    end
    @(posedge clock_in);
    reset_n_in <= 1'b0;
    @(posedge clock_in);
    reset_n_in <= 1'b1;
    {w12, w13} = '0;
    @(negedge clock_in);
    check_all();
    rdc(4'h4);
    final_report();
  end
endmodule : pmx_pin_function_select_tb_top
`default_nettype wire
